/* src/rrs_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rrs_regs.svh"
module rrs_sequencer (
    input wire logic i_clock, // 40 MHz clock
    input wire logic i_rst, // sync reset, active high
    input wire logic [31:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte enables
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [31:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic i_mode_settled_flag, // chip mode is ready
    input wire logic i_payload_available_evt, // payload ready pulse
    input wire logic i_fifo_empty, // fifo drained by host
    input wire logic i_packet_sent_evt, // transmit done pulse
    input wire logic i_strength_wait_expiry, // rssi timeout pulse
    input wire logic i_preamble_wait_expiry, // preamble timeout pulse
    input wire logic i_syncword_wait_expiry, // sync timeout pulse
    input wire logic [7:0] i_rssi_db, // signal strength, 1 dB per lsb
    output logic o_restart_pulse, // re-run agc and afc
    output logic o_relock_pulse, // restart also relocks synthesizer
    output logic [2:0] o_chip_mode, // requested chip mode
    output logic o_tx_power, // transmitter on
    output logic o_rx_power // receiver on
);
    logic [31:0] rxcfg_reg, synccfg_reg, seqcfg_reg;
    logic [15:0] t1_reg, t2_reg;
    rrs_pkg::rrs_seq_e seq_reg;
    rrs_pkg::rrs_ar_e ar_reg;
    rrs_pkg::rrs_mode_e init_mode_reg;
    logic [31:0] ar_cnt_reg;
    logic [7:0] rssi_prev_reg;
    logic aw_hold_reg, w_hold_reg;
    logic [31:0] awaddr_reg, wdata_reg;
    logic [3:0] wstrb_reg;
    logic t1_fire, t2_fire, t1_start, t2_start, seq_stop;
    logic wr_do, rx_mode, coll_hit, any_expiry, manual_req, ar_done;
    logic [31:0] wmask;
    ////////////////////////////////////////////////////////////////////////
    // axi-lite write: address and data latched independently
    assign wr_do = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{wstrb_reg[i]}};
        end
    end
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= 32'h0000_0000;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end else if (wr_do) begin
                aw_hold_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end else if (wr_do) begin
                w_hold_reg <= 1'b0;
            end
            if (wr_do) begin
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_hold_reg;
    assign s_axi_wready = !w_hold_reg;
    assign s_axi_bresp = 2'b00;
    ////////////////////////////////////////////////////////////////////////
    // axi-lite read; unmapped addresses read zero with okay
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            if (s_axi_araddr == `RRS_OFF_RXCFG) begin
                s_axi_rdata <= rxcfg_reg;
            end else if (s_axi_araddr == `RRS_OFF_SYNCCFG) begin
                s_axi_rdata <= synccfg_reg;
            end else if (s_axi_araddr == `RRS_OFF_SEQCFG) begin
                s_axi_rdata <= seqcfg_reg;
            end else if (s_axi_araddr == `RRS_OFF_STATUS) begin
                s_axi_rdata <= {24'h000000, 1'b0, 1'(init_mode_reg == rrs_pkg::RRS_M_SLEEP),
                    ar_reg, 1'b0, seq_reg};
            end else if (s_axi_araddr == `RRS_OFF_TIMER1) begin
                s_axi_rdata <= {16'h0000, t1_reg};
            end else if (s_axi_araddr == `RRS_OFF_TIMER2) begin
                s_axi_rdata <= {16'h0000, t2_reg};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rresp = 2'b00;
    ////////////////////////////////////////////////////////////////////////
    // configuration registers; trigger bits self-clear the cycle after they are written
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            rxcfg_reg <= `RRS_RST_RXCFG;
            synccfg_reg <= `RRS_RST_SYNCCFG;
            seqcfg_reg <= `RRS_RST_SEQCFG;
            t1_reg <= 16'h0000;
            t2_reg <= 16'h0000;
        end else begin
            if (wr_do && awaddr_reg == `RRS_OFF_RXCFG) begin
                rxcfg_reg <= (rxcfg_reg & ~wmask) | (wdata_reg & wmask);
            end else if (rxcfg_reg[`RRS_RX_NO_RELOCK] || rxcfg_reg[`RRS_RX_RELOCK]) begin
                rxcfg_reg[`RRS_RX_NO_RELOCK] <= 1'b0;
                rxcfg_reg[`RRS_RX_RELOCK] <= 1'b0;
            end
            if (wr_do && awaddr_reg == `RRS_OFF_SYNCCFG) begin
                synccfg_reg <= (synccfg_reg & ~wmask) | (wdata_reg & wmask);
            end
            if (wr_do && awaddr_reg == `RRS_OFF_SEQCFG) begin
                seqcfg_reg <= (seqcfg_reg & ~wmask) | (wdata_reg & wmask);
            end else begin
                seqcfg_reg[`RRS_SQ_START] <= 1'b0;
                seqcfg_reg[`RRS_SQ_STOP] <= 1'b0;
            end
            if (wr_do && awaddr_reg == `RRS_OFF_TIMER1) begin
                t1_reg <= wdata_reg[15:0];
            end
            if (wr_do && awaddr_reg == `RRS_OFF_TIMER2) begin
                t2_reg <= wdata_reg[15:0];
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // receiver restart sources
    assign rx_mode = (seq_reg == rrs_pkg::RRS_RECEIVE) || (seq_reg == rrs_pkg::RRS_FRAME_HELD);
    // a trigger met while the mode is unsettled is dropped, so a stale one never fires late
    assign manual_req = (rxcfg_reg[`RRS_RX_NO_RELOCK] || rxcfg_reg[`RRS_RX_RELOCK])
        && i_mode_settled_flag;
    assign coll_hit = rxcfg_reg[`RRS_RX_COLL_EN] && rx_mode
        && (i_rssi_db > rssi_prev_reg)
        && ((i_rssi_db - rssi_prev_reg) >= rxcfg_reg[`RRS_RX_THRESH_LSB +: 8]);
    assign ar_done = (ar_reg == rrs_pkg::RRS_AR_WAIT) && (ar_cnt_reg == 32'h0000_0000);
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            rssi_prev_reg <= 8'h00;
        end else begin
            rssi_prev_reg <= i_rssi_db;
        end
    end
    // automatic rearm after payload: empty fifo, inter-packet wait, optional relock wait
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ar_reg <= rrs_pkg::RRS_AR_IDLE;
            ar_cnt_reg <= 32'h0000_0000;
        end else begin
            case (ar_reg)
                rrs_pkg::RRS_AR_IDLE: begin
                    if (i_payload_available_evt && synccfg_reg[1:0] != 2'b00) begin
                        ar_reg <= rrs_pkg::RRS_AR_EMPTY;
                    end
                end
                rrs_pkg::RRS_AR_EMPTY: begin
                    if (i_fifo_empty) begin
                        ar_reg <= rrs_pkg::RRS_AR_WAIT;
                        ar_cnt_reg <= 32'(synccfg_reg[`RRS_SY_DELAY_LSB +: 8])
                            * 32'(`RRS_WAIT_UNIT)
                            + ((synccfg_reg[1:0] == 2'b10) ? `RRS_RELOCK_CYC : 32'd0);
                    end
                end
                rrs_pkg::RRS_AR_WAIT: begin
                    if (ar_cnt_reg == 32'h0000_0000) begin
                        ar_reg <= rrs_pkg::RRS_AR_IDLE;
                    end else begin
                        ar_cnt_reg <= ar_cnt_reg - 32'd1;
                    end
                end
                default: ar_reg <= rrs_pkg::RRS_AR_IDLE;
            endcase
        end
    end
    // every restart re-runs agc/afc; relock trigger, afc, or mode 10
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_restart_pulse <= 1'b0;
            o_relock_pulse <= 1'b0;
        end else begin
            o_restart_pulse <= manual_req || coll_hit || ar_done;
            o_relock_pulse <= (manual_req && rxcfg_reg[`RRS_RX_RELOCK])
                || (ar_done && synccfg_reg[1:0] == 2'b10)
                || ((manual_req || coll_hit || ar_done) && rxcfg_reg[`RRS_RX_AFC_EN]);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // top level sequencer
    assign any_expiry = i_strength_wait_expiry || i_preamble_wait_expiry
        || i_syncword_wait_expiry;
    assign seq_stop = seqcfg_reg[`RRS_SQ_STOP] || !seqcfg_reg[`RRS_SQ_FSKOOK];
    assign t1_start = (seq_reg == rrs_pkg::RRS_LOW_POWER_CHOICE) && seqcfg_reg[`RRS_SQ_LOWPWR];
    assign t2_start = (seq_reg != rrs_pkg::RRS_RECEIVE) && (seq_reg != rrs_pkg::RRS_FRAME_HELD);
    rrs_interval_timer u_first_interval_timer (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_start(t1_start),
        .i_stop(seq_stop),
        .i_count(t1_reg),
        .o_fire(t1_fire)
    );
    rrs_interval_timer u_second_interval_timer (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_start(t2_start),
        .i_stop(seq_stop),
        .i_count(t2_reg),
        .o_fire(t2_fire)
    );
    // start only from halted; mode at start is remembered as initial
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            seq_reg <= rrs_pkg::RRS_HALTED;
            init_mode_reg <= rrs_pkg::RRS_M_STANDBY;
        end else if (seq_stop) begin
            seq_reg <= rrs_pkg::RRS_HALTED;
        end else begin
            case (seq_reg)
                rrs_pkg::RRS_HALTED: begin
                    if (seqcfg_reg[`RRS_SQ_START]) begin
                        init_mode_reg <= (o_chip_mode == 3'(rrs_pkg::RRS_M_SLEEP))
                            ? rrs_pkg::RRS_M_SLEEP : rrs_pkg::RRS_M_STANDBY;
                        seq_reg <= rrs_pkg::RRS_LOW_POWER_CHOICE;
                    end
                end
                rrs_pkg::RRS_LOW_POWER_CHOICE: begin
                    seq_reg <= seqcfg_reg[`RRS_SQ_LOWPWR] ? rrs_pkg::RRS_IDLE
                        : rrs_pkg::RRS_HALTED;
                end
                rrs_pkg::RRS_IDLE: begin
                    if (t1_fire) begin
                        seq_reg <= seqcfg_reg[`RRS_SQ_FROM_IDLE] ? rrs_pkg::RRS_RECEIVE
                            : rrs_pkg::RRS_TRANSMIT;
                    end
                end
                rrs_pkg::RRS_TRANSMIT: begin
                    if (i_packet_sent_evt) begin
                        seq_reg <= seqcfg_reg[`RRS_SQ_FROM_TX] ? rrs_pkg::RRS_RECEIVE
                            : rrs_pkg::RRS_LOW_POWER_CHOICE;
                    end
                end
                rrs_pkg::RRS_RECEIVE: begin
                    if (t2_fire) begin
                        seq_reg <= rrs_pkg::RRS_LOW_POWER_CHOICE;
                    end else if (any_expiry) begin
                        seq_reg <= rrs_pkg::RRS_EXPIRY;
                    end else if (i_payload_available_evt) begin
                        seq_reg <= rrs_pkg::RRS_FRAME_HELD;
                    end
                end
                rrs_pkg::RRS_FRAME_HELD: begin
                    if (t2_fire || i_fifo_empty) begin
                        seq_reg <= rrs_pkg::RRS_LOW_POWER_CHOICE;
                    end
                end
                rrs_pkg::RRS_EXPIRY: begin
                    case (seqcfg_reg[`RRS_SQ_FROM_TMO_LSB +: 2])
                        2'b00: seq_reg <= rrs_pkg::RRS_RECEIVE;
                        2'b01: seq_reg <= rrs_pkg::RRS_TRANSMIT;
                        2'b10: seq_reg <= rrs_pkg::RRS_LOW_POWER_CHOICE;
                        default: seq_reg <= rrs_pkg::RRS_HALTED;
                    endcase
                end
                default: seq_reg <= rrs_pkg::RRS_HALTED;
            endcase
        end
    end
    // chip mode and power follow the sequencer state
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_chip_mode <= 3'(rrs_pkg::RRS_M_STANDBY);
            o_tx_power <= 1'b0;
            o_rx_power <= 1'b0;
        end else begin
            case (seq_reg)
                rrs_pkg::RRS_HALTED: begin
                    o_chip_mode <= seqcfg_reg[`RRS_SQ_START] ? o_chip_mode
                        : 3'(init_mode_reg);
                    o_tx_power <= 1'b0;
                    o_rx_power <= 1'b0;
                end
                rrs_pkg::RRS_IDLE: begin
                    o_chip_mode <= seqcfg_reg[`RRS_SQ_IDLE] ? 3'(rrs_pkg::RRS_M_SLEEP)
                        : 3'(rrs_pkg::RRS_M_STANDBY);
                    o_tx_power <= 1'b0;
                    o_rx_power <= 1'b0;
                end
                rrs_pkg::RRS_TRANSMIT: begin
                    o_chip_mode <= 3'(rrs_pkg::RRS_M_TX);
                    o_tx_power <= 1'b1;
                    o_rx_power <= 1'b0;
                end
                rrs_pkg::RRS_RECEIVE, rrs_pkg::RRS_FRAME_HELD, rrs_pkg::RRS_EXPIRY: begin
                    o_chip_mode <= 3'(rrs_pkg::RRS_M_RX);
                    o_tx_power <= 1'b0;
                    o_rx_power <= 1'b1;
                end
                default: begin
                    o_chip_mode <= o_chip_mode;
                    o_tx_power <= 1'b0;
                    o_rx_power <= 1'b0;
                end
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // checks
    restart_settled_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (!i_mode_settled_flag && !coll_hit && !ar_done) |=> !o_restart_pulse)
        else $error("restart without mode settled");
    restart_pulse_a: assert property (@(posedge i_clock) disable iff (i_rst)
        manual_req |=> o_restart_pulse) else $error("manual restart lost");
    relock_pulse_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (manual_req && rxcfg_reg[`RRS_RX_RELOCK]) |=> o_relock_pulse)
        else $error("relock missing");
    rearm_off_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (synccfg_reg[1:0] == 2'b00 && ar_reg == rrs_pkg::RRS_AR_IDLE)
        |=> ar_reg == rrs_pkg::RRS_AR_IDLE) else $error("auto rearm while off");
    stop_halts_a: assert property (@(posedge i_clock) disable iff (i_rst)
        seqcfg_reg[`RRS_SQ_STOP] |=> seq_reg == rrs_pkg::RRS_HALTED)
        else $error("stop ignored");
    lowpwr_pass_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (seq_reg == rrs_pkg::RRS_LOW_POWER_CHOICE && !seq_stop)
        |=> seq_reg == (seqcfg_reg[`RRS_SQ_LOWPWR] ? rrs_pkg::RRS_IDLE : rrs_pkg::RRS_HALTED))
        else $error("low power choice stuck");
    idle_wait_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (seq_reg == rrs_pkg::RRS_IDLE && !t1_fire && !seq_stop) |=> seq_reg == rrs_pkg::RRS_IDLE)
        else $error("idle left without timer");
    tx_power_a: assert property (@(posedge i_clock) disable iff (i_rst)
        seq_reg == rrs_pkg::RRS_TRANSMIT |=> o_tx_power) else $error("tx not powered");
    expiry_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (seq_reg == rrs_pkg::RRS_RECEIVE && any_expiry && !t2_fire && !seq_stop)
        |=> seq_reg == rrs_pkg::RRS_EXPIRY) else $error("timeout missed");
    trigger_clear_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (manual_req && !wr_do) |=> !rxcfg_reg[`RRS_RX_NO_RELOCK]) else $error("trigger stuck");
    cov_manual_c: cover property (@(posedge i_clock) manual_req);
    cov_auto_c: cover property (@(posedge i_clock) ar_done);
    cov_coll_c: cover property (@(posedge i_clock) coll_hit);
    cov_idle_rx_c: cover property (@(posedge i_clock)
        seq_reg == rrs_pkg::RRS_IDLE ##1 seq_reg == rrs_pkg::RRS_RECEIVE);
endmodule : rrs_sequencer
`default_nettype wire

/* src/rrs_regs.svh */
// Behaviour
// - no-relock trigger restarts without synthesizer relock; code still relocks when afc enable is set
// - relock trigger restarts with synthesizer relock
// - restart accepted only while mode settled; code gates only trigger restarts, not collision or auto rearm
// - rearm mode 00 means no auto restart
// - mode 01 waits fifo empty then delay
// - mode 10 adds extra relock delay
// - collision enable restarts on strength jump
// - strength rise compared with 8-bit threshold, 1 dB per lsb
// - every restart re-runs gain and frequency
// - sequencer only in fsk/ook modulation
// - start bit in low power records mode
// - stop bit forces sequencer off anytime
// - off via low power restores initial mode
// - idle holds chosen mode, waits first timer
// - transmit powers tx, receive powers rx
// - frame held keeps rx on with packet
// - low power choice passes straight through
// - any of three timeouts enters expiry state
// - two interval timers drive transitions
// - idle choice 0 standby, 1 sleep
// - low power bit 0 off, 1 idle
`ifndef RRS_REGS_SVH
`define RRS_REGS_SVH
`define RRS_OFF_RXCFG 32'h0000_0000
`define RRS_OFF_SYNCCFG 32'h0000_0004
`define RRS_OFF_SEQCFG 32'h0000_0008
`define RRS_OFF_STATUS 32'h0000_000C
`define RRS_OFF_TIMER1 32'h0000_0010
`define RRS_OFF_TIMER2 32'h0000_0014
// receiver config fields
`define RRS_RX_NO_RELOCK 0
`define RRS_RX_RELOCK 1
`define RRS_RX_AFC_EN 2
`define RRS_RX_COLL_EN 3
`define RRS_RX_THRESH_LSB 8
`define RRS_RX_THRESH_W 8
// sync config fields
`define RRS_SY_MODE_LSB 0
`define RRS_SY_DELAY_LSB 8
`define RRS_SY_DELAY_W 8
// sequencer config fields
`define RRS_SQ_START 0
`define RRS_SQ_STOP 1
`define RRS_SQ_IDLE 2
`define RRS_SQ_LOWPWR 3
`define RRS_SQ_FROM_IDLE 4
`define RRS_SQ_FROM_TX 5
`define RRS_SQ_FROM_TMO_LSB 6
`define RRS_SQ_FSKOOK 8
// reset values
`define RRS_RST_RXCFG 32'h0000_0A00
`define RRS_RST_SYNCCFG 32'h0000_0400
`define RRS_RST_SEQCFG 32'h0000_0100
// inter-packet wait unit and extra relock wait, in cycles
`define RRS_WAIT_UNIT 16'h0028
`define RRS_RELOCK_NS 32'd150000
`define RRS_CLK_NS 32'd25
`define RRS_RELOCK_CYC (((`RRS_RELOCK_NS) + (`RRS_CLK_NS) - 32'd1) / (`RRS_CLK_NS))
`endif

/* src/rrs_pkg.sv */
package rrs_pkg;
    typedef enum logic [2:0] {
        RRS_HALTED, RRS_IDLE, RRS_TRANSMIT, RRS_RECEIVE,
        RRS_FRAME_HELD, RRS_LOW_POWER_CHOICE, RRS_EXPIRY
    } rrs_seq_e;
    typedef enum logic [2:0] {
        RRS_M_SLEEP, RRS_M_STANDBY, RRS_M_FSTX, RRS_M_TX, RRS_M_FSRX, RRS_M_RX
    } rrs_mode_e;
    typedef enum logic [1:0] {RRS_AR_IDLE, RRS_AR_EMPTY, RRS_AR_WAIT} rrs_ar_e;
endpackage : rrs_pkg

/* src/rrs_interval_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// one-shot interval counter; fires a single pulse after the loaded count
module rrs_interval_timer (
    input wire logic i_clock, // clock
    input wire logic i_rst, // sync reset
    input wire logic i_start, // load and run
    input wire logic i_stop, // abandon count
    input wire logic [15:0] i_count, // cycles to wait
    output logic o_fire // one-cycle expiry
);
    logic [15:0] count_reg;
    logic run_reg;

    // count down; a zero load still fires after one cycle
    always_ff @(posedge i_clock) begin
        if (i_rst || i_stop) begin
            count_reg <= 16'h0000;
            run_reg <= 1'b0;
            o_fire <= 1'b0;
        end else if (i_start) begin
            count_reg <= i_count;
            run_reg <= 1'b1;
            o_fire <= 1'b0;
        end else if (run_reg && count_reg == 16'h0000) begin
            run_reg <= 1'b0;
            o_fire <= 1'b1;
        end else begin
            count_reg <= run_reg ? count_reg - 16'h0001 : count_reg;
            o_fire <= 1'b0;
        end
    end
endmodule : rrs_interval_timer
`default_nettype wire

/* dv/rrs_radio_model.sv */
`timescale 1ns/1ps
`default_nettype none
// radio front end: mode settles a few cycles after each chip mode change
module rrs_radio_model (
    input wire logic i_clock, // clock
    input wire logic [2:0] i_chip_mode, // mode asked for
    input wire logic i_hold, // keep mode unsettled
    output logic o_settled // mode ready level
);
    logic [2:0] last_mode;
    logic [2:0] cnt;
    initial begin
        last_mode = 3'h1;
        cnt = 3'h0;
    end
    // a mode change restarts the settling count, so a restart can be refused
    always @(posedge i_clock) begin
        last_mode <= i_chip_mode;
        if (i_chip_mode !== last_mode) cnt <= 3'h4;
        else if (cnt != 3'h0) cnt <= cnt - 3'h1;
    end
    assign o_settled = !i_hold && (cnt == 3'h0);
endmodule : rrs_radio_model
`default_nettype wire

/* dv/rx_restart_and_mode_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module rx_restart_and_mode_sequencer_tb;
    logic i_clock = 0, i_rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic [31:0] awa = 0, wd = 0, ara = 0, rd;
    logic awr, wr_, bv, arr, rv, settled, hold = 0, pay = 0, fe = 0, tmo = 0;
    logic [1:0] br, rr;
    logic [7:0] rssi = 8'h0A;
    logic rp, lp, txp, rxp;
    logic [2:0] cm;
    int fail_count = 0, samples_checked = 0, nr = 0, nl = 0;
    initial forever #12.5 i_clock = ~i_clock;
    rrs_sequencer i_rrs_sequencer (.i_clock(i_clock), .i_rst(i_rst), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
        .i_mode_settled_flag(settled), .i_payload_available_evt(pay), .i_fifo_empty(fe),
        .i_packet_sent_evt(1'b0), .i_strength_wait_expiry(1'b0),
        .i_preamble_wait_expiry(tmo), .i_syncword_wait_expiry(1'b0), .i_rssi_db(rssi),
        .o_restart_pulse(rp), .o_relock_pulse(lp), .o_chip_mode(cm), .o_tx_power(txp),
        .o_rx_power(rxp));
    rrs_radio_model i_rrs_radio_model (.i_clock(i_clock), .i_chip_mode(cm), .i_hold(hold),
        .o_settled(settled));
    // pulse tallies stand in for edge-exact checks of one-cycle outputs
    always @(posedge i_clock) begin
        if (rp === 1'b1) nr <= nr + 1;
        if (lp === 1'b1) nl <= nl + 1;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task wr(input logic [31:0] a, input logic [31:0] d);
        awa <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        bre <= 1;
        forever begin
            @(posedge i_clock);
            if (awv && awr) awv <= 0;
            if (wv && wr_) wv <= 0;
            if (bv) break;
        end
    endtask : wr
    task rdk(input logic [31:0] a, input logic [31:0] e);
        ara <= a;
        arv <= 1;
        rre <= 1;
        forever begin
            @(posedge i_clock);
            if (arv && arr) arv <= 0;
            if (rv) break;
        end
        chk(rd, e);
    endtask : rdk
    task complete_run;
        if (fail_count == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run
    // watchdog sized well above the longest scenario
    initial begin
        repeat (30000) @(posedge i_clock);
        fail_count++;
        complete_run();
    end
    initial begin
        repeat (10) @(posedge i_clock);
        i_rst <= 0;
        @(posedge i_clock);
        rdk(32'h0, 32'h0A00);
        rdk(32'h4, 32'h0400);
        rdk(32'h8, 32'h0100);
        rdk(32'hC, 32'h0);
        rdk(32'h20, 32'h0);
        // restart asked while unsettled is dropped, not deferred
        hold <= 1;
        wr(32'h0, 32'h0A01);
        repeat (20) @(posedge i_clock);
        hold <= 0;
        repeat (10) @(posedge i_clock);
        chk(nr, 0);
        rdk(32'h0, 32'h0A00);
        wr(32'h0, 32'h0A01);
        repeat (10) @(posedge i_clock);
        chk(nr, 1);
        chk(nl, 0);
        wr(32'h0, 32'h0A02);
        repeat (10) @(posedge i_clock);
        chk(nr, 2);
        chk(nl, 1);
        // auto rearm after payload: fifo drained, then 1 unit of 40 cycles
        wr(32'h4, 32'h0101);
        pay <= 1;
        @(posedge i_clock);
        pay <= 0;
        repeat (60) @(posedge i_clock);
        chk(nr, 2);
        fe <= 1;
        repeat (30) @(posedge i_clock);
        chk(nr, 2);
        repeat (30) @(posedge i_clock);
        chk(nr, 3);
        // mode 10 adds 6000 relock cycles on top of the 40-cycle wait
        wr(32'h4, 32'h0102);
        pay <= 1;
        @(posedge i_clock);
        pay <= 0;
        repeat (6000) @(posedge i_clock);
        chk(nr, 3);
        repeat (100) @(posedge i_clock);
        chk(nr, 4);
        chk(nl, 2);
        // sequencer: start, idle, first timer into receive; second timer parked long
        wr(32'h10, 32'h14);
        wr(32'h14, 32'hFFFF);
        wr(32'h8, 32'h0119);
        repeat (120) @(posedge i_clock);
        rdk(32'hC, 32'h3);
        chk(rxp, 1);
        chk(txp, 0);
        chk(cm, 32'h5);
        wr(32'h0, 32'h0508);
        rssi <= 8'h0E;
        repeat (10) @(posedge i_clock);
        chk(nr, 4);
        rssi <= 8'h14;
        repeat (10) @(posedge i_clock);
        chk(nr, 5);
        // preamble timeout: expiry, low power choice, idle, then first timer back to rx
        wr(32'h8, 32'h0198);
        tmo <= 1;
        @(posedge i_clock);
        tmo <= 0;
        repeat (5) @(posedge i_clock);
        rdk(32'hC, 32'h1);
        chk(cm, 32'h1);
        repeat (30) @(posedge i_clock);
        rdk(32'hC, 32'h3);
        wr(32'h8, 32'h0102);
        repeat (4) @(posedge i_clock);
        rdk(32'hC, 32'h0);
        chk(cm, 32'h1);
        rdk(32'h8, 32'h0100);
        complete_run();
    end
endmodule : rx_restart_and_mode_sequencer_tb
`default_nettype wire
